//--- logic/pdsr_cfg.svh
// Constants for the same-power renegotiation sequencer
//
// Notes on behaviour
// - Same-power request answered with Accept, no transition
// - GoodCRC for Accept needed before power-ready step
// - Wait transition delay, send PS_RDY, supply unchanged
// - No-change decision from policy manager or supply
// - Bus in tolerance within 285 ms of transition
// - Swap-standby Source becomes Sink within 15 ms
// - Short-circuit recovery within 120 s of removal
// - Source recovery lasts 0.66 s to 1 s
// - Transition delay between 25 ms and 35 ms
`ifndef PDSR_CFG_SVH
`define PDSR_CFG_SVH

// ****************************************************************
// Clock and time bases
// ****************************************************************
`define PDSR_CLK_HZ                 40000000
`define PDSR_MS_PER_S               1000
`define PDSR_CYCLES_PER_MS          (`PDSR_CLK_HZ / `PDSR_MS_PER_S)

// ****************************************************************
// Timing figures, each in its own unit
// ****************************************************************
`define PDSR_SRC_TRANSITION_MIN_MS  25
`define PDSR_SRC_TRANSITION_MAX_MS  35
`define PDSR_SRC_READY_MAX_MS       285
`define PDSR_NEW_SINK_MAX_MS        15
`define PDSR_SHORT_RECOVER_MAX_S    120
`define PDSR_SRC_RECOVER_MIN_MS     660
`define PDSR_SRC_RECOVER_MAX_S      1

// ****************************************************************
// Counts in millisecond ticks (least times gain one tick)
// ****************************************************************
`define PDSR_DELAY_TICKS            (`PDSR_SRC_TRANSITION_MIN_MS + 1)
`define PDSR_READY_TICKS            (`PDSR_SRC_READY_MAX_MS)
`define PDSR_NEW_SINK_TICKS         (`PDSR_NEW_SINK_MAX_MS)
`define PDSR_SHORT_TICKS            (`PDSR_SHORT_RECOVER_MAX_S * `PDSR_MS_PER_S)
`define PDSR_RECOVER_TICKS          (`PDSR_SRC_RECOVER_MIN_MS + 1)
`define PDSR_RECOVER_MAX_TICKS      (`PDSR_SRC_RECOVER_MAX_S * `PDSR_MS_PER_S)

// ****************************************************************
// Watchdog slots
// ****************************************************************
`define PDSR_WD_READY               0
`define PDSR_WD_NEW_SINK            1
`define PDSR_WD_SHORT               2
`define PDSR_WD_NUM                 3

`endif

//--- logic/pdsr_pkg.sv
// Types shared by the same-power renegotiation sequencer
`default_nettype none
package pdsr_pkg;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	// Sequence states, Gray coded along the normal path from IDLE to DONE
	typedef enum logic [2:0] {
		PDSR_IDLE      = 3'h0,
		PDSR_ACCEPT    = 3'h1,
		PDSR_CRC_ACC   = 3'h3,
		PDSR_DELAY     = 3'h2,
		PDSR_PS_RDY    = 3'h6,
		PDSR_CRC_RDY   = 3'h7,
		PDSR_DONE      = 3'h5
	} pdsr_state_type;

	// Message kinds that this sequencer sends
	typedef enum logic {
		PDSR_MSG_ACCEPT = 1'h0,
		PDSR_MSG_PS_RDY = 1'h1
	} pdsr_kind_type;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	// Incoming request from the policy engine front end
	typedef struct packed {
		logic valid;       // One-cycle request pulse
		logic same_power;  // Requested voltage and current equal present ones
	} pdsr_req_type;

	// Outgoing message request toward the protocol layer
	typedef struct packed {
		logic          valid;  // Held until taken
		pdsr_kind_type kind;   // Which message
	} pdsr_tx_type;

endpackage
`default_nettype wire

//--- logic/pdsr_ms_tick.sv
// Millisecond enable pulse divider for the sequencer timers
`timescale 1ns/1ps
`default_nettype none
`include "pdsr_cfg.svh"
module pdsr_ms_tick #(
	parameter int CYCLES_PER_MS = `PDSR_CYCLES_PER_MS
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	output logic      tick
);
	import pdsr_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] cnt;   // Cycles into the current millisecond
		logic        tick;  // Registered pulse
	} pdsr_tick_state_type;

	pdsr_tick_state_type st;       // Registered state
	pdsr_tick_state_type next_st;  // Next state

	// Refuse a divider too short to give a one-cycle pulse
	if (CYCLES_PER_MS < 2) begin : g_chk
		$error("pdsr_ms_tick: CYCLES_PER_MS must be at least 2");
	end

	// Count and wrap, pulse on the wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 32'(CYCLES_PER_MS - 1)) begin
			next_st.cnt = 32'h0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end

	// Register the whole state
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

endmodule
`default_nettype wire

//--- logic/pdsr_sequencer.sv
// Source-side sequencer for a same-power renegotiation, with supply watchdogs
`timescale 1ns/1ps
`default_nettype none
`include "pdsr_cfg.svh"
module pdsr_sequencer #(
	parameter int CYCLES_PER_MS = `PDSR_CYCLES_PER_MS,
	parameter int WD_W          = 17
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire pdsr_pkg::pdsr_req_type req,
	input  wire logic                 decide_by_supply,
	input  wire logic                 dpm_no_change,
	input  wire logic                 supply_no_change,
	output pdsr_pkg::pdsr_tx_type     tx,
	input  wire logic                 tx_ready,
	input  wire logic                 goodcrc_rx,
	input  wire logic                 proto_abort,
	output logic                      supply_hold,
	output logic                      seq_busy,
	output logic                      seq_done,
	output logic                      seq_fail,
	output logic                      req_forward,
	input  wire logic [2:0]           wd_start,
	input  wire logic [2:0]           wd_met_pin,
	output logic [2:0]                wd_busy,
	output logic [2:0]                wd_miss,
	input  wire logic                 rec_start,
	output logic                      src_recovering,
	output logic                      rec_done
);
	import pdsr_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The longest window is the short-circuit one, in ms ticks
	if (WD_W < 17 || WD_W > 31) begin : g_chk_w
		$error("pdsr_sequencer: WD_W must be 17 to 31");
	end

	// ****************************************************************
	// Watchdog limits in ms ticks
	// ****************************************************************
	localparam logic [2:0][WD_W-1:0] WD_LIMIT = {
		WD_W'(`PDSR_SHORT_TICKS),
		WD_W'(`PDSR_NEW_SINK_TICKS),
		WD_W'(`PDSR_READY_TICKS)
	};
	localparam logic [5:0] DELAY_TICKS   = 6'(`PDSR_DELAY_TICKS);
	localparam logic [9:0] RECOVER_TICKS = 10'(`PDSR_RECOVER_TICKS);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		pdsr_state_type        state;     // Sequence position
		pdsr_kind_type         kind;      // Message being offered
		logic [5:0]            dly;       // Transition delay ticks
		logic                  done;      // Completion pulse
		logic                  fail;      // Abort pulse
		logic                  fwd;       // Request handed elsewhere
		logic [2:0]            sync1;     // First synchroniser stage
		logic [2:0]            sync2;     // Second synchroniser stage
		logic [2:0][WD_W-1:0]  wd_cnt;    // Watchdog tick counts
		logic [2:0]            wd_busy;   // Watchdog armed
		logic [2:0]            wd_miss;   // Deadline missed
		logic [9:0]            rec_cnt;   // Recovery ticks
		logic                  rec_on;    // Recovery interval active
		logic                  rec_done;  // Recovery end pulse
	} pdsr_seq_state_type;

	pdsr_seq_state_type st;       // Registered state
	pdsr_seq_state_type next_st;  // Next state
	logic               ms_tick;  // One-cycle millisecond enable
	logic               no_change;

	// ****************************************************************
	// Millisecond time base
	// ****************************************************************
	pdsr_ms_tick #(
		.CYCLES_PER_MS (CYCLES_PER_MS)
	) u_tick (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.tick    (ms_tick)
	);

	// Pick the party that decides no transition is needed
	always_comb begin
		if (decide_by_supply) begin
			no_change = supply_no_change;
		end else begin
			no_change = dpm_no_change;
		end
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.fail = 1'b0;
		next_st.fwd = 1'b0;
		next_st.rec_done = 1'b0;
		// Pin levels pass two flops before anything looks at them
		next_st.sync1 = wd_met_pin;
		next_st.sync2 = st.sync1;

		// Message sequence
		case (st.state)
			PDSR_IDLE: begin
				if (req.valid && req.same_power && no_change) begin
					next_st.state = PDSR_ACCEPT;
					next_st.kind = PDSR_MSG_ACCEPT;
				end else if (req.valid) begin
					// Any real change belongs to the full transition path
					next_st.fwd = 1'b1;
				end
			end
			PDSR_ACCEPT: begin
				if (tx_ready) begin
					next_st.state = PDSR_CRC_ACC;
				end
			end
			PDSR_CRC_ACC: begin
				// Delay only starts once the Accept is acknowledged
				if (goodcrc_rx) begin
					next_st.state = PDSR_DELAY;
					next_st.dly = 6'h0;
				end
			end
			PDSR_DELAY: begin
				if (st.dly == DELAY_TICKS) begin
					next_st.state = PDSR_PS_RDY;
					next_st.kind = PDSR_MSG_PS_RDY;
				end else if (ms_tick) begin
					next_st.dly = st.dly + 6'h1;
				end
			end
			PDSR_PS_RDY: begin
				if (tx_ready) begin
					next_st.state = PDSR_CRC_RDY;
				end
			end
			PDSR_CRC_RDY: begin
				if (goodcrc_rx) begin
					next_st.state = PDSR_DONE;
				end
			end
			PDSR_DONE: begin
				next_st.state = PDSR_IDLE;
				next_st.done = 1'b1;
			end
			default: begin
				next_st.state = PDSR_IDLE;
			end
		endcase

		// Protocol reset or lost message ends the sequence at once
		if (proto_abort && st.state != PDSR_IDLE) begin
			next_st.state = PDSR_IDLE;
			next_st.fail = 1'b1;
		end

		// Supply deadlines: start arms, met level disarms, limit flags
		for (int i = 0; i < `PDSR_WD_NUM; i++) begin
			if (wd_start[i]) begin
				next_st.wd_busy[i] = 1'b1;
				next_st.wd_miss[i] = 1'b0;
				next_st.wd_cnt[i] = '0;
			end else if (st.wd_busy[i] && st.sync2[i]) begin
				next_st.wd_busy[i] = 1'b0;
			end else if (st.wd_busy[i] && st.wd_cnt[i] == WD_LIMIT[i]) begin
				next_st.wd_busy[i] = 1'b0;
				next_st.wd_miss[i] = 1'b1;
			end else if (st.wd_busy[i] && ms_tick) begin
				next_st.wd_cnt[i] = st.wd_cnt[i] + WD_W'(1);
			end
		end

		// Recovery interval held for its least time, well inside 1 s
		if (rec_start) begin
			next_st.rec_on = 1'b1;
			next_st.rec_cnt = 10'h0;
		end else if (st.rec_on && st.rec_cnt == RECOVER_TICKS) begin
			next_st.rec_on = 1'b0;
			next_st.rec_done = 1'b1;
		end else if (st.rec_on && ms_tick) begin
			next_st.rec_cnt = st.rec_cnt + 10'h1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Offer stands until the protocol layer takes it
	assign tx.valid = (st.state == PDSR_ACCEPT) || (st.state == PDSR_PS_RDY);
	assign tx.kind = st.kind;
	// Supply output stays put for the whole sequence
	assign supply_hold = (st.state != PDSR_IDLE);
	assign seq_busy = (st.state != PDSR_IDLE);
	assign seq_done = st.done;
	assign seq_fail = st.fail;
	assign req_forward = st.fwd;
	assign wd_busy = st.wd_busy;
	assign wd_miss = st.wd_miss;
	assign src_recovering = st.rec_on;
	assign rec_done = st.rec_done;

endmodule
`default_nettype wire

//--- bench/pdsr_sequencer_sva.sv
// Port assertions for the same-power sequencer
`timescale 1ns/1ps
`default_nettype none
module pdsr_sequencer_chk #(
	parameter int CYCLES_PER_MS = 4
) (
	input wire logic                   ref_clk,
	input wire logic                   sys_rst,
	input wire pdsr_pkg::pdsr_req_type req,
	input wire logic                   decide_by_supply,
	input wire logic                   dpm_no_change,
	input wire logic                   supply_no_change,
	input wire pdsr_pkg::pdsr_tx_type  tx,
	input wire logic                   goodcrc_rx,
	input wire logic                   proto_abort,
	input wire logic                   supply_hold,
	input wire logic                   seq_busy,
	input wire logic                   seq_done,
	input wire logic                   seq_fail,
	input wire logic                   req_forward,
	input wire logic [2:0]             wd_start,
	input wire logic [2:0]             wd_met_pin,
	input wire logic [2:0]             wd_busy,
	input wire logic [2:0]             wd_miss,
	input wire logic                   rec_start,
	input wire logic                   src_recovering,
	input wire logic                   rec_done
);
	import pdsr_pkg::*;
	// ****************************************************************
	// Helper counters
	// ****************************************************************
	int   gap; // Cycles since last acknowledge
	int   nsw; // Cycles since window start
	int   rc;  // Cycles since recovery start
	logic sel; // Selected no-change verdict
	assign sel = decide_by_supply ? supply_no_change : dpm_no_change;
	// Each counter restarts on its cause
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap <= 0;
			nsw <= 0;
			rc  <= 0;
		end else begin
			gap <= goodcrc_rx ? 0 : gap + 1;
			nsw <= wd_start[1] ? 0 : nsw + 1;
			rc  <= rec_start ? 0 : rc + 1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	serve_accept_a: assert property (
		req.valid && req.same_power && sel && !seq_busy && !seq_done && !seq_fail
		|=> tx.valid && tx.kind == PDSR_MSG_ACCEPT) else $error("no accept offer");
	req_forward_a: assert property (
		req.valid && !(req.same_power && sel) && !seq_busy && !seq_done && !seq_fail
		|=> req_forward && !tx.valid) else $error("request not forwarded");
	hold_supply_a: assert property (
		tx.valid |-> supply_hold && seq_busy) else $error("supply not held");
	delay_window_a: assert property (
		$rose(tx.valid && tx.kind == PDSR_MSG_PS_RDY) |-> gap >= 25 * CYCLES_PER_MS
		&& gap <= 35 * CYCLES_PER_MS) else $error("power ready delay off");
	ready_ack_a: assert property (
		goodcrc_rx && seq_busy && !tx.valid && tx.kind == PDSR_MSG_PS_RDY && !proto_abort
		|=> ##1 seq_done && !seq_busy) else $error("no done after ack");
	abort_fail_a: assert property (
		proto_abort && seq_busy |=> seq_fail && !seq_busy ##1 !seq_fail)
		else $error("abort not reported");
	ready_arm_a: assert property (
		wd_start[0] |=> wd_busy[0] && !wd_miss[0]) else $error("ready watchdog idle");
	ready_met_a: assert property (
		(wd_met_pin[0] && !wd_start[0])[*3] |=> !wd_busy[0]) else $error("met ignored");
	new_sink_miss_a: assert property (
		$rose(wd_miss[1]) |-> !wd_busy[1] && nsw >= 14 * CYCLES_PER_MS
		&& nsw <= 15 * CYCLES_PER_MS + 2) else $error("window miss time off");
	short_arm_a: assert property (
		wd_start[2] |=> wd_busy[2] && !wd_miss[2]) else $error("short watchdog idle");
	recover_len_a: assert property (
		$fell(src_recovering) |-> rec_done && rc >= 660 * CYCLES_PER_MS
		&& rc <= 661 * CYCLES_PER_MS + 2) else $error("recovery length off");
endmodule
bind pdsr_sequencer pdsr_sequencer_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_inst (.*);
`default_nettype wire

//--- bench/pdsr_sink_model.sv
// Behavioural protocol layer and sink facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pdsr_sink_model #(
	parameter int PST_NS = 1000000 // Sink transition timer span
) (
	input  wire logic                  ref_clk,
	input  wire pdsr_pkg::pdsr_tx_type tx,
	input  wire logic [1:0]            lat,
	input  wire logic                  drop_crc,
	output logic                       tx_ready,
	output logic                       goodcrc_rx,
	output logic                       pst_expired
);
	import pdsr_pkg::*;
	pdsr_kind_type k;     // Kind being taken
	time           acc_t; // Transition timer start
	// Take each offer after lat cycles, then acknowledge it unless drop_crc is set
	initial begin
		tx_ready = 1'b0;
		goodcrc_rx = 1'b0;
		pst_expired = 1'b0;
		acc_t = 0;
		forever begin
			@(posedge ref_clk);
			#2;
			if (tx.valid === 1'b1) begin
				k = tx.kind;
				repeat (lat) @(posedge ref_clk);
				#2 tx_ready = 1'b1;
				@(posedge ref_clk);
				#2 tx_ready = 1'b0;
				// Timer runs from accept to power ready
				if (k == PDSR_MSG_ACCEPT) begin
					acc_t = $time;
				end else begin
					pst_expired = ($time - acc_t > PST_NS);
				end
				repeat (2) @(posedge ref_clk);
				#2 goodcrc_rx = !drop_crc;
				@(posedge ref_clk);
				#2 goodcrc_rx = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/test_pdsr_sequencer.sv
// Self-checking bench for the same-power sequencer
`timescale 1ns/1ps
`default_nettype none
module test_pdsr_sequencer;
	import pdsr_pkg::*;
	localparam int CPM = 4; // Short millisecond keeps the run brief
	logic ref_clk = 1'b0, sys_rst = 1'b1, decide_by_supply = 1'b0;
	logic dpm_no_change = 1'b0, supply_no_change = 1'b0, proto_abort = 1'b0;
	logic rec_start = 1'b0, drop_crc = 1'b0;
	logic [1:0] lat = 2'h0;
	logic [2:0] wd_start = 3'h0, wd_met_pin = 3'h0;
	pdsr_req_type req = '0;
	pdsr_tx_type tx;
	logic tx_ready, goodcrc_rx, supply_hold, seq_busy, seq_done, seq_fail;
	logic req_forward, src_recovering, rec_done, pst_expired;
	logic [2:0] wd_busy, wd_miss;
	int fail_count = 0, checks_done = 0, n;
	pdsr_sequencer #(.CYCLES_PER_MS(CPM)) pdsr_sequencer_inst (.*);
	// Sink timer scaled to the short millisecond: 35 ms of 25 ns cycles
	pdsr_sink_model #(.PST_NS(35 * CPM * 25)) pdsr_sink_model_inst (.*);
	always #12.5 ref_clk = ~ref_clk;
	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask
	task automatic chk_int(input int got, input int lo, input int hi, input string what);
		checks_done++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("ERROR %0t %s %0d", $time, what, got);
		end
	endtask
	// Inputs move just after the edge
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
		#2;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return seq_done;
			1: return !wd_busy[1];
			default: return !src_recovering;
		endcase
	endfunction
	// Bounded wait; a hang ends the run
	task automatic wait_for(input int s, input int lim, output int c);
		c = 0;
		while (sig(s) !== 1'b1 && c < lim) begin
			cyc(1);
			c++;
		end
		if (c >= lim) begin
			fail_count++;
			$display("ERROR %0t wait ran out", $time);
			end_of_test();
		end
	endtask
	// One request; served only for same power with no change
	task automatic run_req(input logic s, input logic d, input logic p, input logic u);
		logic e;
		e = s && (d ? u : p);
		req = '{valid: 1'b1, same_power: s};
		decide_by_supply = d;
		dpm_no_change = p;
		supply_no_change = u;
		cyc(1);
		req.valid = 1'b0;
		chk_bit(tx.valid, e, "offer");
		chk_bit(req_forward, !e, "forward");
		chk_bit(supply_hold, e, "hold on");
		if (e) begin
			chk_bit(tx.kind, PDSR_MSG_ACCEPT, "kind");
			wait_for(0, 60 * CPM, n);
			chk_int(n, 25 * CPM, 36 * CPM, "delay");
			chk_bit(supply_hold, 1'b0, "hold");
		end
		cyc(1);
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(60029));
		repeat (20) @(posedge ref_clk);
		#2 sys_rst = 1'b0;
		cyc(1);
		chk_bit(seq_busy, 1'b0, "idle");
		// Every verdict source, then random requests back to back
		for (int i = 0; i < 16; i++) begin
			lat = 2'($urandom_range(0, 3));
			if (i < 8) begin
				run_req(1'b1, i[2], i[1], i[0]);
			end else begin
				run_req(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
			end
		end
		// Lost acknowledge stalls on the Accept, then abort
		// No wait for done here: the sequence must never finish
		drop_crc = 1'b1;
		req = '{valid: 1'b1, same_power: 1'b1};
		decide_by_supply = 1'b0;
		dpm_no_change = 1'b1;
		cyc(1);
		req.valid = 1'b0;
		chk_bit(tx.valid, 1'b1, "stall offer");
		cyc(40 * CPM);
		chk_bit(tx.valid, 1'b0, "ready without ack");
		chk_bit(tx.kind, PDSR_MSG_ACCEPT, "moved on without ack");
		chk_bit(seq_busy, 1'b1, "stall busy");
		proto_abort = 1'b1;
		cyc(1);
		proto_abort = 1'b0;
		chk_bit(seq_fail, 1'b1, "fail");
		drop_crc = 1'b0;
		chk_bit(pst_expired, 1'b0, "sink timer");
		// Watchdogs: met, missed, long one met
		wd_start = 3'h1;
		cyc(1);
		wd_start = 3'h2;
		chk_bit(wd_busy[0], 1'b1, "armed");
		cyc(1);
		wd_start = 3'h0;
		wd_met_pin = 3'h1;
		cyc(4);
		chk_bit(wd_busy[0] | wd_miss[0], 1'b0, "met");
		wait_for(1, 20 * CPM, n);
		chk_int(n, 14 * CPM - 2, 15 * CPM + 1, "window");
		chk_bit(wd_miss[1], 1'b1, "miss");
		wd_start = 3'h4;
		cyc(1);
		wd_start = 3'h0;
		chk_bit(wd_busy[2], 1'b1, "short armed");
		wd_met_pin = 3'h5;
		cyc(4);
		chk_bit(wd_busy[2] | wd_miss[2], 1'b0, "short met");
		// Recovery interval length
		rec_start = 1'b1;
		cyc(1);
		rec_start = 1'b0;
		wait_for(2, 700 * CPM, n);
		chk_int(n, 660 * CPM - 1, 661 * CPM + 1, "recovery");
		chk_bit(rec_done, 1'b1, "rec done");
		end_of_test();
	end
endmodule
`default_nettype wire
